// *** core/low_power_mode_control.v ***
// Low-power mode controller: deep sleep, idle, recovery and wake cause.
`include "power_mode_consts.vh"

module low_power_mode_control (
  // Clock and reset
  input  wire                      clk,
  input  wire                      rst_b,
  // APB slave
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [11:0]               paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output reg                       pready,
  output reg                       pslverr,
  // Core requests and events
  input  wire                      sleep_instr,
  input  wire                      idle_instr,
  input  wire                      irq_pending,
  input  wire                      sys_exception,
  input  wire                      wdog_timeout,
  input  wire                      brownout_reset,
  input  wire                      ext_reset_b,
  input  wire [`WAKE_PINS-1:0]     wake_pins,
  input  wire [`PTR_WIDTH-1:0]     vector_data,
  input  wire [`PTR_WIDTH-1:0]     next_fetch_ptr,
  // Gating outputs
  output reg                       sys_clk_en,
  output reg                       core_run,
  output reg                       vector_fetch,
  output reg  [`PTR_WIDTH-1:0]     instruction_pointer,
  output reg                       watchdog_counter_en,
  output reg                       watchdog_osc_en,
  output reg                       brownout_monitor_en,
  output reg                       wdog_exception_req,
  output reg  [`PERIPH_COUNT-1:0]  periph_run,
  output reg  [`PERIPH_COUNT-1:0]  periph_low_power
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_RUN     = 2'h0;
  localparam [1:0] ST_IDLE    = 2'h1;
  localparam [1:0] ST_SLEEP   = 2'h2;
  localparam [1:0] ST_RECOVER = 2'h3;

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  reg rst_meta;
  reg rst_sync_b;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  wire [`WAKE_PINS-1:0] pin_s;
  wire                  brown_s;
  wire                  ext_rst_s_b;

  // Wake pins are asynchronous and may bounce; only changes seen after both flops count.
  genvar g;
  generate
    for (g = 0; g < `WAKE_PINS; g = g + 1) begin : g_pin
      sync2 u_sync (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .d     (wake_pins[g]),
        .q     (pin_s[g])
      );
    end
  endgenerate

  sync2 u_brown_sync (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .d     (brownout_reset),
    .q     (brown_s)
  );

  // External reset is synchronised inverted so that reset value means "not asserted".
  wire ext_rst_asserted;
  sync2 u_ext_sync (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .d     (~ext_reset_b),
    .q     (ext_rst_asserted)
  );
  assign ext_rst_s_b = ~ext_rst_asserted;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0]               ctrl;
  reg [7:0]                cause;
  reg [`WAKE_PINS-1:0]     wake_en;
  reg [`PERIPH_COUNT-1:0]  periph_en;
  reg [1:0]                state;
  reg [3:0]                rec_cnt;
  reg                      rec_wdog;
  reg [`WAKE_PINS-1:0]     pin_prev;

  // Recovery counts as deep so that peripherals stay parked until the core restarts.
  wire deep = (state == ST_SLEEP) | (state == ST_RECOVER);
  wire wdog_sleep_on = ctrl[`CTRL_WDOG_EN_BIT] & ctrl[`CTRL_WDOG_SLEEP_BIT]
                       & ~ctrl[`CTRL_OPT_WOSC_OFF];

  // Edge detect reads only the synchronised copies.
  wire pin_wake = |((pin_s ^ pin_prev) & wake_en); // [R19]
  wire idle_wake = irq_pending | sys_exception | wdog_timeout
                   | ctrl[`CTRL_INSTANT_BIT]; // [R13] [R21]
  // A reset pin or a brown-out overrides every mode, deep sleep included.
  wire reset_evt = brown_s | ~ext_rst_s_b;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  // One wait state: the access phase is taken on its first edge and pready answers on the
  // next, so prdata is registered and no combinational path runs from paddr to the bus.
  // The ~pready term keeps an access phase that is still held from being taken twice.
  wire acc = psel & penable & ~pready;
  wire wr  = acc & pwrite;

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (acc) begin
        if (paddr == `PM_CTRL_ADDR) begin
          prdata <= ctrl;
        end else if (paddr == `PM_STATUS_ADDR) begin
          prdata <= {30'h0000_0000, state};
        end else if (paddr == `PM_CAUSE_ADDR) begin
          prdata <= {24'h00_0000, cause};
        end else if (paddr == `PM_WAKE_EN_ADDR) begin
          prdata <= {24'h00_0000, wake_en};
        end else if (paddr == `PM_PERIPH_EN_ADDR) begin
          prdata <= {24'h00_0000, periph_en};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Unlisted control bits are not stored, so they always read back as zero.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl      <= `CTRL_RESET;
      wake_en   <= 8'h00;
      periph_en <= 8'h00;
    end else begin
      if (wr && paddr == `PM_CTRL_ADDR) begin
        ctrl <= {25'h000_0000, pwdata[6:0]};
      end
      if (wr && paddr == `PM_WAKE_EN_ADDR) begin
        wake_en <= pwdata[7:0];
      end
      if (wr && paddr == `PM_PERIPH_EN_ADDR) begin
        periph_en <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state    <= ST_RUN;
      rec_cnt  <= 4'h0;
      rec_wdog <= 1'b0;
      pin_prev <= 8'h00;
      cause    <= `CAUSE_POR_VALUE;
    end else begin
      pin_prev <= pin_s;
      if (reset_evt) begin
        // Resets override any mode; cause holds the latest event only.
        state <= ST_RUN; // [R13]
        cause <= {3'h0, ~ext_rst_s_b, brown_s, 3'h0};
      end else begin
        case (state)
          ST_RUN: begin
            if (sleep_instr) begin
              state <= ST_SLEEP; // [R01]
            end else if (idle_instr) begin
              state <= ST_IDLE; // [R08]
            end
          end
          ST_IDLE: begin
            if (idle_wake) begin
              state <= ST_RUN; // [R13] [R21]
            end
          end
          ST_SLEEP: begin
            // Apart from a reset event, only recovery leaves deep sleep; the core cannot run here.
            if (pin_wake || (wdog_timeout && wdog_sleep_on)) begin
              state    <= ST_RECOVER; // [R07] [R19]
              rec_wdog <= wdog_timeout & wdog_sleep_on;
              rec_cnt  <= `RECOVER_CYCLES;
            end
          end
          default: begin
            // Recovery: the clock is back but the core stays halted while the count runs
            // down, which leaves time for the vector fetch issued at a count of one.
            if (rec_cnt == 4'h0) begin
              state <= ST_RUN; // [R07]
              cause <= {1'b0, 1'b1, rec_wdog, 5'h00}; // [R17] [R18]
            end else begin
              rec_cnt <= rec_cnt - 4'h1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Gating outputs
  // ----------------------------------------
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sys_clk_en          <= 1'b1;
      core_run            <= 1'b0;
      vector_fetch        <= 1'b0;
      instruction_pointer <= `RESET_VECTOR_ADDR;
      watchdog_counter_en <= 1'b0;
      watchdog_osc_en     <= 1'b1;
      brownout_monitor_en <= 1'b1;
      wdog_exception_req  <= 1'b0;
    end else begin
      sys_clk_en   <= (state != ST_SLEEP); // [R02] [R09]
      core_run     <= (state == ST_RUN) & ~sleep_instr & ~idle_instr; // [R02] [R10]
      vector_fetch <= (state == ST_RECOVER) & (rec_cnt == 4'h1); // [R20]
      if (state == ST_RECOVER && rec_cnt == 4'h0) begin
        instruction_pointer <= vector_data; // [R20]
      end else if (core_run && state == ST_RUN && !sleep_instr && !idle_instr) begin
        // Copy the core's pointer only once the core really runs again; on the edge between
        // leaving recovery and the restart its pointer is stale and would overwrite the
        // freshly loaded vector.
        instruction_pointer <= next_fetch_ptr; // [R20]
      end
      // Pointer holds while idle or sleeping. [R03] [R10]
      // The option bit removes the oscillator in every mode, not only in deep sleep.
      watchdog_osc_en <= ~ctrl[`CTRL_OPT_WOSC_OFF]
                         & (~deep | wdog_sleep_on); // [R04] [R11] [R15]
      watchdog_counter_en <= ctrl[`CTRL_WDOG_EN_BIT] & ~ctrl[`CTRL_OPT_WOSC_OFF]
                             & (~deep | wdog_sleep_on); // [R04] [R11]
      brownout_monitor_en <= ~ctrl[`CTRL_OPT_BROWN_OFF]
                             & (~deep | ctrl[`CTRL_BROWN_SLEEP_BIT]); // [R05] [R15]
      // Watchdog exception is serviced after recovery completes.
      wdog_exception_req <= (state == ST_RECOVER) & (rec_cnt == 4'h0)
                            & rec_wdog & ctrl[`CTRL_WDOG_EXC_BIT]; // [R18]
    end
  end

  // ----------------------------------------
  // Peripheral gating
  // ----------------------------------------
  // Each gate adds one flop and the output stage another, so a peripheral stops two edges
  // after the mode changes; nothing reaches it in that window as the core is already
  // halted.
  wire [`PERIPH_COUNT-1:0] p_run;
  wire [`PERIPH_COUNT-1:0] p_lp;

  generate
    for (g = 0; g < `PERIPH_COUNT; g = g + 1) begin : g_per
      periph_gate u_gate (
        .clk        (clk),
        .rst_b      (rst_sync_b),
        .enable     (periph_en[g]),
        .deep_sleep (deep),
        .run        (p_run[g]),
        .low_power  (p_lp[g])
      );
    end
  endgenerate

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      periph_run       <= 8'h00;
      periph_low_power <= 8'hff;
    end else begin
      periph_run       <= p_run; // [R06] [R12]
      periph_low_power <= p_lp; // [R14]
    end
  end

endmodule

// *** core/periph_gate.v ***
// Clock-enable and low-power request for one peripheral.
module periph_gate (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Control
  input  wire enable,
  input  wire deep_sleep,
  // Result
  output reg  run,
  output reg  low_power
);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run       <= 1'b0;
      low_power <= 1'b1; // [R14]
    end else begin
      run       <= enable & ~deep_sleep; // [R06] [R12]
      low_power <= ~enable | deep_sleep; // [R14]
    end
  end

endmodule

// *** core/power_mode_consts.vh ***
// Constants for the low-power mode controller: register map, fields, reset values, timing.
// Function
// R01: Deep-sleep instruction puts the device into deep sleep.
// R02: Deep sleep stops the system clock and halts the core.
// R03: Instruction pointer holds its value throughout deep sleep.
// R04: Watchdog and its RC oscillator run in deep sleep only if enabled.
// R05: Brown-out monitor runs in deep sleep only if its option bit allows.
// R06: All other peripherals stay inactive during deep sleep.
// R07: Deep sleep ends only through the sleep-recovery sequence; a reset event here returns straight to run.
// R08: Idle instruction puts the device into idle mode.
// R09: Idle keeps the system clock running.
// R10: Idle stops the core and freezes the instruction pointer.
// R11: Idle keeps watchdog oscillator running; counter counts if enabled.
// R12: Idle leaves all other peripherals clocked and operating.
// R13: Idle ends on interrupt, exception, watchdog, resets or instant recovery.
// R14: Peripherals drop to low power after reset and when disabled.
// R15: Option bits can disable brown-out monitor and watchdog oscillator.
// R16: Software should disable brown-out, watchdog and external clock first.
// R17: Any deep-sleep recovery sets the sleep-wake cause flag.
// R18: Watchdog timeout in deep sleep recovers, sets watchdog and sleep flags.
// R19: Any edge on an enabled wake pin starts deep-sleep recovery.
// R20: Recovery fetches the reset vector into the instruction pointer.
// R21: Wake from idle by interrupt resumes the core; state preserved.
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PM_CTRL_ADDR        12'h000
`define PM_STATUS_ADDR      12'h004
`define PM_CAUSE_ADDR       12'h008
`define PM_WAKE_EN_ADDR     12'h00c
`define PM_PERIPH_EN_ADDR   12'h010

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_WDOG_EN_BIT    0
`define CTRL_WDOG_SLEEP_BIT 1
`define CTRL_WDOG_EXC_BIT   2
`define CTRL_BROWN_SLEEP_BIT 3
`define CTRL_OPT_BROWN_OFF  4
`define CTRL_OPT_WOSC_OFF   5
`define CTRL_INSTANT_BIT    6
`define CTRL_RESET          32'h0000_0001

// ----------------------------------------
// Cause register fields
// ----------------------------------------
`define CAUSE_POR_BIT       7
`define CAUSE_SLEEP_BIT     6
`define CAUSE_WDOG_BIT      5
`define CAUSE_EXT_BIT       4
`define CAUSE_BROWN_BIT     3
`define CAUSE_POR_VALUE     8'h80

// ----------------------------------------
// Widths, counts and recovery timing
// ----------------------------------------
`define PERIPH_COUNT        8
`define WAKE_PINS           8
`define PTR_WIDTH           24
`define RECOVER_CYCLES      4'h4
`define RESET_VECTOR_ADDR   24'h000004

`endif

// *** core/sync2.v ***
// Two-flip-flop synchroniser for one asynchronous level.
module sync2 (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Data
  input  wire d,
  output reg  q
);

  reg meta;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** dv/core_model.sv ***
// Behavioural processor core issuing mode instructions and fetch pointers.
module core_model #(parameter logic [23:0] VEC = 24'h00a5c0) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  input  wire         core_run,
  // Core side
  output logic        sleep_instr,
  output logic        idle_instr,
  output logic [23:0] vector_data,
  output logic [23:0] next_fetch_ptr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sleep_instr = 1'b0;
  initial idle_instr = 1'b0;
  assign vector_data = VEC;
  // The pointer only advances while the core may run, so a frozen core shows up as a gap.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      next_fetch_ptr <= 24'h000100;
    else if (core_run)
      next_fetch_ptr <= next_fetch_ptr + 24'h000004;
  end
  task issue(input logic deep);
    @(posedge clk);
    if (deep) sleep_instr <= 1'b1;
    else idle_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    idle_instr <= 1'b0;
  endtask
endmodule

// *** dv/low_power_mode_control_tb.sv ***
// Self-checking testbench for the low-power mode controller.
`include "power_mode_consts.vh"
module low_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err, exc_seen;
  logic irq_pending = 0, sys_exception = 0, wdog_timeout = 0, brown = 0, ext_rst_b = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0] wake_pins = 8'h00;
  logic [23:0] ipv;
  wire [31:0] prdata;
  wire [23:0] vdat, nfp, ip;
  wire [7:0] prun, plow;
  wire pready, pslverr, sl, id, sys_clk_en, core_run, vfetch, wcnt, wosc, bmon, wexc;
  integer fail_count = 0, n_compared = 0;
  always #2 clk = ~clk;
  core_model u_core (.clk(clk), .rst_b(rst_b), .core_run(core_run), .sleep_instr(sl),
    .idle_instr(id), .vector_data(vdat), .next_fetch_ptr(nfp));
  low_power_mode_control u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr(sl), .idle_instr(id), .irq_pending(irq_pending),
    .sys_exception(sys_exception), .wdog_timeout(wdog_timeout), .brownout_reset(brown),
    .ext_reset_b(ext_rst_b), .wake_pins(wake_pins), .vector_data(vdat), .next_fetch_ptr(nfp),
    .sys_clk_en(sys_clk_en), .core_run(core_run), .vector_fetch(vfetch),
    .instruction_pointer(ip), .watchdog_counter_en(wcnt), .watchdog_osc_en(wosc),
    .brownout_monitor_en(bmon), .wdog_exception_req(wexc), .periph_run(prun),
    .periph_low_power(plow));
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 16) begin fail_count++; conclude(); end
  endtask
  task wait_run;
    integer k;
    k = 0;
    while (core_run !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
      if (wexc === 1'b1) exc_seen = 1;
    end
    if (k >= 60) begin fail_count++; conclude(); end
  endtask
  task scen_reset;
    apb(0, `PM_CAUSE_ADDR, 0); check("cause", rd, 32'h80);
    apb(0, `PM_CTRL_ADDR, 0); check("ctrl", rd, `CTRL_RESET);
    check("plow", plow, 8'hff);
    apb(0, 12'h020, 0); check("slverr", err, 1'b1);
    check("unmapped", rd, 0);
    apb(1, `PM_PERIPH_EN_ADDR, 32'h0f);
    repeat (3) @(posedge clk);
    #1 check("prun", prun, 8'h0f);
    check("plow_en", plow, 8'hf0);
  endtask
  task scen_idle(input int src);
    u_core.issue(0);
    repeat (3) @(posedge clk);
    #1 ipv = ip;
    check("idle_run", core_run, 1'b0);
    check("idle_clk", sys_clk_en, 1'b1);
    check("idle_prun", prun, 8'h0f);
    check("idle_osc", wosc, 1'b1);
    check("idle_wcnt", wcnt, 1'b1);
    repeat (4) @(posedge clk);
    #1 check("idle_ip", ip, ipv);
    @(posedge clk);
    if (src == 1) sys_exception <= 1;
    else if (src == 2) wdog_timeout <= 1;
    else irq_pending <= 1;
    wait_run;
    irq_pending <= 0; sys_exception <= 0; wdog_timeout <= 0;
    check("idle_wake", core_run, 1'b1);
    check("kept_prun", prun, 8'h0f);
  endtask
  task scen_rst_evt(input logic br);
    u_core.issue(0);
    repeat (3) @(posedge clk);
    #1 check("re_idle", core_run, 1'b0);
    @(posedge clk);
    if (br) brown <= 1; else ext_rst_b <= 0;
    repeat (2) @(posedge clk);
    brown <= 0; ext_rst_b <= 1;
    wait_run;
    check("re_wake", core_run, 1'b1);
    apb(0, `PM_CAUSE_ADDR, 0);
    check("re_cause", rd, br ? 32'h08 : 32'h10);
  endtask
  task scen_instant;
    apb(1, `PM_CTRL_ADDR, 32'h41);
    u_core.issue(0);
    @(posedge clk);
    #1 check("inst_stop", core_run, 1'b0);
    wait_run;
    check("inst_wake", core_run, 1'b1);
  endtask
  task scen_sleep(input logic [31:0] ctrl, input logic wd);
    apb(1, `PM_CTRL_ADDR, ctrl);
    apb(1, `PM_WAKE_EN_ADDR, 32'h01);
    u_core.issue(1);
    repeat (4) @(posedge clk);
    #1 ipv = ip;
    check("sl_clk", sys_clk_en, 1'b0);
    check("sl_prun", prun, 8'h00);
    check("sl_wcnt", wcnt, wd);
    check("sl_osc", wosc, wd);
    check("sl_bmon", bmon, wd);
    @(posedge clk);
    irq_pending <= 1;
    wake_pins <= wake_pins ^ 8'h02;
    repeat (10) @(posedge clk);
    irq_pending <= 0;
    #1 check("sl_stay", sys_clk_en, 1'b0);
    check("sl_ip", ip, ipv);
    exc_seen = 0;
    @(posedge clk);
    if (wd) wdog_timeout <= 1; else wake_pins <= wake_pins ^ 8'h01;
    @(posedge clk);
    wdog_timeout <= 0;
    wait_run;
    check("wk_ip", ip, u_core.VEC);
    apb(0, `PM_CAUSE_ADDR, 0);
    check("wk_cause", rd, wd ? 32'h60 : 32'h40);
    check("wk_exc", exc_seen, wd);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    scen_reset;
    scen_idle(0);
    scen_idle(1);
    scen_idle(2);
    scen_rst_evt(1'b0);
    scen_rst_evt(1'b1);
    scen_instant;
    scen_sleep(32'h38, 1'b0);
    scen_sleep(32'h0f, 1'b1);
    conclude;
  end
endmodule

// *** dv/lpm_chk.sv ***
// Port-level assertion checker for the low-power mode controller.
`include "power_mode_consts.vh"
module lpm_chk (
  // Clock and reset
  input wire                      clk,
  input wire                      rst_b,
  // Requests
  input wire                      psel,
  input wire                      penable,
  input wire                      pready,
  input wire                      sleep_instr,
  input wire                      idle_instr,
  input wire [`PTR_WIDTH-1:0]     vector_data,
  // Gating
  input wire                      sys_clk_en,
  input wire                      core_run,
  input wire                      vector_fetch,
  input wire [`PTR_WIDTH-1:0]     instruction_pointer,
  input wire                      watchdog_counter_en,
  input wire                      watchdog_osc_en,
  input wire [`PERIPH_COUNT-1:0]  periph_run,
  input wire [`PERIPH_COUNT-1:0]  periph_low_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_gate; !core_run ##1 !sys_clk_en; endsequence
  sequence s_recover; (!core_run)[*3] ##[0:6] vector_fetch; endsequence
  property p_sleep; sleep_instr && core_run && sys_clk_en |=> s_gate; endproperty
  property p_ip_hold; !sys_clk_en |=> $stable(instruction_pointer); endproperty
  property p_periph_off; !sys_clk_en && !$past(sys_clk_en) |-> periph_run == 8'h00; endproperty
  property p_lp_excl; (periph_run & periph_low_power) == 8'h00; endproperty
  property p_idle_clk; idle_instr && !sleep_instr && core_run |=> sys_clk_en[*4]; endproperty
  property p_idle_stop;
    idle_instr && !sleep_instr && core_run && sys_clk_en |=> !core_run;
  endproperty
  property p_recover; $rose(sys_clk_en) |-> s_recover; endproperty
  property p_vec_load; vector_fetch |-> ##[1:3] instruction_pointer == vector_data; endproperty
  property p_wdog; watchdog_counter_en |-> watchdog_osc_en; endproperty
  property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry gating wrong");
  a_ip_hold: assert property (p_ip_hold) else $error("pointer moved in sleep");
  a_periph_off: assert property (p_periph_off) else $error("peripheral ran in sleep");
  a_lp_excl: assert property (p_lp_excl) else $error("peripheral both run and low");
  a_idle_clk: assert property (p_idle_clk) else $error("clock stopped in idle");
  a_idle_stop: assert property (p_idle_stop) else $error("core ran in idle");
  a_recover: assert property (p_recover) else $error("recovery sequence wrong");
  a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
  a_wdog: assert property (p_wdog) else $error("counter without oscillator");
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");
endmodule

bind low_power_mode_control lpm_chk u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .sleep_instr(sleep_instr), .idle_instr(idle_instr), .vector_data(vector_data),
  .sys_clk_en(sys_clk_en), .core_run(core_run), .vector_fetch(vector_fetch),
  .instruction_pointer(instruction_pointer), .watchdog_counter_en(watchdog_counter_en),
  .watchdog_osc_en(watchdog_osc_en), .periph_run(periph_run),
  .periph_low_power(periph_low_power));
